// ==== inc/msg_report_consts.svh ====
// constants for the received-message sideband port
// assumes inclusion by bare name from design files and the package
`ifndef MSG_REPORT_CONSTS_SVH
`define MSG_REPORT_CONSTS_SVH
`define MSG_KIND_W 5
`define MSG_DATA_W 8
`define MSG_KIND_ERR_COR 5'h00
`define MSG_KIND_ERR_NONFATAL 5'h01
`define MSG_KIND_ERR_FATAL 5'h02
`define MSG_KIND_INT_FIRST 5'h03
`define MSG_KIND_INT_LAST 5'h0a
`define MSG_KIND_PM_PME 5'h0b
`define MSG_KIND_PME_TO_ACK 5'h0c
`define MSG_KIND_PME_TURN_OFF 5'h0d
`define MSG_KIND_PM_NAK 5'h0e
`define MSG_KIND_SLOT_POWER 5'h0f
`define MSG_KIND_LTR 5'h10
`define MSG_KIND_RSVD 5'h11
`define MSG_KIND_UNLOCK 5'h12
`define MSG_KIND_VDM0 5'h13
`define MSG_KIND_VDM1 5'h14
`define MSG_LEN_SHORT 4'h2
`define MSG_LEN_LONG 4'h6
`define MSG_LEN_VDM_NODATA 4'h4
`define MSG_LEN_VDM_DATA 4'h8
`define MSG_GAP_CYCLES 1
`define MSG_STEP_W 4
`endif

// ==== inc/msg_report_pkg.sv ====
// types for the received-message sideband port
// assumes msg_report_consts.svh is on the include path
`include "msg_report_consts.svh"
package msg_report_pkg;
	typedef logic [`MSG_KIND_W-1:0] msg_kind_type;
	typedef logic [`MSG_DATA_W-1:0] msg_byte_type;
	// gray along idle -> send -> gap; gap -> idle flips both bits
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_send = 2'b01,
		st_gap = 2'b11
	} report_state_type;
endpackage : msg_report_pkg

// ==== design/msg_byte_select.sv ====
// byte selector for one message: picks the parameter byte for a step
// assumes the caller holds the captured fields stable during the message
`timescale 1ns/100ps
module msg_byte_select (
	// captured message fields
	input wire logic [7:0] req_bus,
	input wire logic [7:0] req_devfn,
	input wire logic [15:0] vendor_id,
	input wire logic [31:0] payload,
	input wire logic [15:0] snoop_lat,
	input wire logic [15:0] nosnoop_lat,
	input wire logic is_ltr,
	input wire logic is_vdm,
	// step within the message, zero based
	input wire logic [3:0] step,
	// selected byte
	output logic [7:0] sel_byte
);
	// three byte tails follow the common two requester bytes
	wire [7:0] pay_byte;
	wire [7:0] ltr_byte;
	wire [7:0] vdm_byte;
	wire [1:0] pay_idx = is_vdm ? 2'(step - 4'h4) : 2'(step - 4'h2);
	assign pay_byte = payload[{pay_idx, 3'b000} +: 8];
	assign ltr_byte = (step == 4'h2) ? snoop_lat[7:0] : (step == 4'h3) ? snoop_lat[15:8] :
		(step == 4'h4) ? nosnoop_lat[7:0] : nosnoop_lat[15:8];
	assign vdm_byte = (step == 4'h2) ? vendor_id[7:0] : (step == 4'h3) ? vendor_id[15:8] : pay_byte;
	// order: bus, devfn, then kind-specific tail
	always_comb begin
		if (step == 4'h0)
			sel_byte = req_bus;
		else if (step == 4'h1)
			sel_byte = req_devfn;
		else if (is_ltr)
			sel_byte = ltr_byte;
		else if (is_vdm)
			sel_byte = vdm_byte;
		else
			sel_byte = pay_byte;
	end
endmodule : msg_byte_select

// ==== design/msg_report.sv ====
// received-message sideband: serialises decoded link messages to user logic
// assumes the decoder offers one message at a time with valid/ready
//
// Summary of operation
// - valid held back-to-back, length by kind
// - one parameter byte per valid cycle
// - at least one idle cycle between messages
// - port silent unless enabled at configuration
// - drive 5-bit kind while valid
// - errors 0..2, INTx assert/deassert 3..10
// - power messages and slot limit 11..15
// - LTR 16, Unlock 18, vendor 19,20
// - slot power: requester then payload LSB first
// - LTR: requester, snoop, then no-snoop latency
// - vendor: 4 or 8 cycles, ID then payload
//
// timing of one message, counted in enabled clock edges:
//   edge 0: in_valid and in_ready high, fields captured, state goes to send
//   edge 1: first report register load, msg_valid rises after it
//   edge L: last parameter byte loaded, state goes to gap
//   edge L+1: msg_valid falls, state returns to idle
//   edge L+2: in_ready is high again, so the next message is offered here
// the source sees ready low for L+1 cycles; that buys the idle gap on the
// report side without any buffering of a second message.
`timescale 1ns/100ps
`include "msg_report_consts.svh"
module msg_report (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// configuration strap
	input wire logic port_enable,
	// decoded message from the link side
	input wire logic in_valid,
	output logic in_ready,
	input wire msg_report_pkg::msg_kind_type in_kind,
	input wire logic [7:0] in_req_bus,
	input wire logic [7:0] in_req_devfn,
	input wire logic [15:0] in_vendor_id,
	input wire logic in_has_data,
	input wire logic [31:0] in_payload,
	input wire logic [15:0] in_snoop_lat,
	input wire logic [15:0] in_nosnoop_lat,
	// user-side report
	output logic msg_valid,
	output msg_report_pkg::msg_byte_type msg_data,
	output msg_report_pkg::msg_kind_type msg_kind
);
	import msg_report_pkg::*;

	report_state_type state;
	report_state_type next_state;
	msg_kind_type kind;
	logic [7:0] req_bus;
	logic [7:0] req_devfn;
	logic [15:0] vendor_id;
	logic [31:0] payload;
	logic [15:0] snoop_lat;
	logic [15:0] nosnoop_lat;
	logic has_data;
	logic [`MSG_STEP_W-1:0] step;
	logic [`MSG_STEP_W-1:0] length;
	logic enabled;

	// kind classification of an incoming message
	wire in_is_slot = (in_kind == `MSG_KIND_SLOT_POWER);
	wire in_is_ltr = (in_kind == `MSG_KIND_LTR);
	wire in_is_vdm = (in_kind == `MSG_KIND_VDM0) || (in_kind == `MSG_KIND_VDM1);
	// the two-byte families, each decoded by its own code range
	wire in_is_err = (in_kind <= `MSG_KIND_ERR_FATAL);
	wire in_is_intx = (in_kind >= `MSG_KIND_INT_FIRST) && (in_kind <= `MSG_KIND_INT_LAST);
	wire in_is_pm = (in_kind >= `MSG_KIND_PM_PME) && (in_kind <= `MSG_KIND_PM_NAK);
	wire in_is_unlock = (in_kind == `MSG_KIND_UNLOCK);
	wire in_is_short = in_is_err || in_is_intx || in_is_pm || in_is_unlock;
	// reserved kinds (17, 21..31) are not decodable and are dropped;
	// built as "none of the known kinds" so a new code cannot slip through
	wire in_reserved = !(in_is_short || in_is_slot || in_is_ltr || in_is_vdm);
	wire [`MSG_STEP_W-1:0] in_len = (in_is_slot || in_is_ltr) ? `MSG_LEN_LONG :
		in_is_vdm ? (in_has_data ? `MSG_LEN_VDM_DATA : `MSG_LEN_VDM_NODATA) :
		`MSG_LEN_SHORT;
	wire is_ltr = (kind == `MSG_KIND_LTR);
	wire is_vdm = (kind == `MSG_KIND_VDM0) || (kind == `MSG_KIND_VDM1);
	wire last_step = (step == length - 4'h1);
	// accept only in idle; a disabled port drains the source without reporting
	wire take = in_valid && (state == st_idle);
	wire start = take && enabled && !in_reserved;
	wire [7:0] cur_byte;
	// next values of the report registers; zero data outside a message
	wire next_valid = (state == st_send);
	wire [7:0] next_data = (state == st_send) ? cur_byte : 8'h00;

	msg_byte_select u_sel (
		.req_bus(req_bus),
		.req_devfn(req_devfn),
		.vendor_id(vendor_id),
		.payload(payload),
		.snoop_lat(snoop_lat),
		.nosnoop_lat(nosnoop_lat),
		.is_ltr(is_ltr),
		.is_vdm(is_vdm),
		.step(step),
		.sel_byte(cur_byte)
	);

	// sequencing: send for length cycles, then one forced idle cycle
	always_comb begin
		case (state)
			st_idle: next_state = start ? st_send : st_idle;
			st_send: next_state = last_step ? st_gap : st_send;
			st_gap: next_state = st_idle;
			default: next_state = st_idle;
		endcase
	end

	// enable is a configuration-time strap, resampled on every enabled clock edge while idle
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			enabled <= 1'b0;
		else if (clk_en && state == st_idle)
			enabled <= port_enable;
	end

	// ready leaves a flip-flop; it follows next_state so it always equals idle
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			in_ready <= 1'b1;
		else if (clk_en)
			in_ready <= (next_state == st_idle);
	end

	// state and step counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= st_idle;
			step <= 4'h0;
		end else if (clk_en) begin
			state <= next_state;
			step <= (state == st_send && !last_step) ? step + 4'h1 : 4'h0;
		end
	end

	// capture fields once; holding them keeps the kind stable for the message
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			kind <= 5'h00;
			length <= 4'h0;
			has_data <= 1'b0;
			req_bus <= 8'h00;
			req_devfn <= 8'h00;
			vendor_id <= 16'h0000;
			payload <= 32'h0000_0000;
			snoop_lat <= 16'h0000;
			nosnoop_lat <= 16'h0000;
		end else if (clk_en && start) begin
			kind <= in_kind;
			length <= in_len;
			has_data <= in_has_data;
			req_bus <= in_req_bus;
			req_devfn <= in_req_devfn;
			vendor_id <= in_vendor_id;
			payload <= in_payload;
			snoop_lat <= in_snoop_lat;
			nosnoop_lat <= in_nosnoop_lat;
		end
	end

	// outputs registered; one cycle behind the internal step
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			msg_valid <= 1'b0;
			msg_data <= 8'h00;
			msg_kind <= 5'h00;
		end else if (clk_en) begin
			msg_valid <= next_valid;
			msg_data <= next_data;
			msg_kind <= kind;
		end
	end
endmodule : msg_report

// ==== test/msg_report_sva.sv ====
// checker for the received-message sideband port
// assumes a bind onto msg_report, one clock domain
`timescale 1ns/100ps
module msg_report_sva (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// input side
	input wire logic port_enable,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire msg_report_pkg::msg_kind_type in_kind,
	input wire logic [7:0] in_req_bus,
	// report
	input wire logic msg_valid,
	input wire msg_report_pkg::msg_byte_type msg_data,
	input wire msg_report_pkg::msg_kind_type msg_kind
);
	import msg_report_pkg::*;
	logic [3:0] run;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// length of the current valid run, so long runs need no repetition operator
	always_ff @(posedge clock or posedge rst) begin
		if (rst) run <= 4'h0;
		else run <= msg_valid ? run + 4'h1 : 4'h0;
	end
	sequence s_take; in_valid && in_ready && clk_en; endsequence
	sequence s_on; port_enable && $past(port_enable) && !$past(rst); endsequence
	property p_report; s_take ##0 s_on ##0 (in_kind <= 5'h14 && in_kind != 5'h11) |-> ##2 msg_valid; endproperty
	a_report: assert property (p_report) else $error("message not reported");
	property p_silent; s_take ##0 (!port_enable && !$past(port_enable)) |-> ##2 !msg_valid; endproperty
	a_silent: assert property (p_silent) else $error("report while disabled");
	property p_first; $rose(msg_valid) |-> msg_data == $past(in_req_bus, 2) && msg_kind == $past(in_kind, 2); endproperty
	a_first: assert property (p_first) else $error("bad first byte or kind");
	property p_gap; $fell(msg_valid) |=> !msg_valid; endproperty
	a_gap: assert property (p_gap) else $error("no idle gap");
	property p_min; $rose(msg_valid) |=> msg_valid; endproperty
	a_min: assert property (p_min) else $error("valid too short");
	property p_max; msg_valid |-> run < 4'h8; endproperty
	a_max: assert property (p_max) else $error("valid too long");
	property p_hold; msg_valid ##1 msg_valid |-> $stable(msg_kind); endproperty
	a_hold: assert property (p_hold) else $error("kind changed");
	property p_code; msg_valid |-> msg_kind <= 5'h14 && msg_kind != 5'h11; endproperty
	a_code: assert property (p_code) else $error("reserved kind shown");
	property p_busy; msg_valid |-> !in_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready during report");
endmodule : msg_report_sva

// ==== test/msg_sink.sv ====
// user-side sink: keeps the bytes and kind of the last reported message
// assumes it samples the report on the rising clock edge
`timescale 1ns/100ps
module msg_sink (
	// clock
	input wire logic clock,
	// report
	input wire logic msg_valid,
	input wire msg_report_pkg::msg_byte_type msg_data,
	input wire msg_report_pkg::msg_kind_type msg_kind
);
	import msg_report_pkg::*;
	msg_byte_type got [0:15];
	msg_kind_type kind;
	int n = 0, msgs = 0;
	logic was = 1'b0;
	// a rise starts a new message, so the byte index restarts
	always @(posedge clock) begin
		if (msg_valid && !was) begin
			n = 0;
			msgs++;
		end
		if (msg_valid) got[n[3:0]] = msg_data;
		if (msg_valid) kind = msg_kind;
		if (msg_valid) n++;
		was = msg_valid;
	end
endmodule : msg_sink

// ==== test/test_msg_report.sv ====
// self-checking bench for the received-message sideband port
// assumes design, checker and sink are compiled first
`timescale 1ns/100ps
module test_msg_report;
	import msg_report_pkg::*;
	typedef struct packed {logic [4:0] k; logic d; logic [3:0] len;} row_type;
	row_type rows [0:5] = '{'{5'h0f, 1'b0, 4'h6}, '{5'h10, 1'b0, 4'h6}, '{5'h13, 1'b0, 4'h4},
		'{5'h13, 1'b1, 4'h8}, '{5'h14, 1'b0, 4'h4}, '{5'h14, 1'b1, 4'h8}};
	logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, port_enable = 1'b1;
	logic in_valid = 1'b0, in_has_data = 1'b0, in_ready, msg_valid;
	msg_kind_type in_kind = 5'h00, msg_kind;
	msg_byte_type msg_data;
	logic [7:0] in_req_bus = 8'h00, in_req_devfn = 8'h00;
	logic [15:0] in_vendor_id = 16'hbeef, in_snoop_lat = 16'h6655, in_nosnoop_lat = 16'h8877;
	logic [31:0] in_payload = 32'h44332211;
	int miscompares = 0, n_checks = 0;
	msg_report dut_u (.clock, .rst, .clk_en, .port_enable, .in_valid, .in_ready, .in_kind,
		.in_req_bus, .in_req_devfn, .in_vendor_id, .in_has_data, .in_payload, .in_snoop_lat,
		.in_nosnoop_lat, .msg_valid, .msg_data, .msg_kind);
	msg_sink sink_u (.clock, .msg_valid, .msg_data, .msg_kind);
	initial begin
		forever #10 clock = ~clock;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// offer one message at a falling edge; len 0 means it must stay unreported
	task send(input logic [4:0] k, input logic d, input int len);
		logic [63:0] w;
		int m0;
		repeat (20) if (in_ready !== 1'b1) @(negedge clock);
		m0 = sink_u.msgs;
		{in_kind, in_has_data, in_valid} = {k, d, 1'b1};
		in_req_bus = 8'h40 + 8'(k);
		in_req_devfn = 8'h80 ^ 8'(k);
		@(negedge clock);
		in_valid = 1'b0;
		repeat (len + 4) @(negedge clock);
		w = {in_payload, in_vendor_id, in_req_devfn, in_req_bus};
		if (k == 5'h0f) w = {16'h0, in_payload, in_req_devfn, in_req_bus};
		if (k == 5'h10) w = {16'h0, in_nosnoop_lat, in_snoop_lat, in_req_devfn, in_req_bus};
		chk(sink_u.msgs - m0, 32'(len != 0));
		if (len != 0) begin
			chk(sink_u.n, len);
			chk(sink_u.kind, k);
			for (int i = 0; i < len; i++) chk(sink_u.got[i], w[8*i +: 8]);
		end
	endtask : send
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// hang guard, far beyond the two hundred or so cycles the run needs
	initial begin
		#100us;
		miscompares++;
		conclude;
	end
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		chk(msg_valid, 1'b0);
		@(negedge clock);
		// every two-cycle kind, one after another, each checked before the next is offered
		for (int k = 0; k <= 18; k++) if (k < 15 || k == 18) send(5'(k), 1'b0, 2);
		foreach (rows[i]) send(rows[i].k, rows[i].d, int'(rows[i].len));
		send(5'h11, 1'b0, 0);
		send(5'h1f, 1'b0, 0);
		port_enable = 1'b0;
		repeat (2) @(negedge clock);
		send(5'h00, 1'b0, 0);
		port_enable = 1'b1;
		repeat (2) @(negedge clock);
		send(5'h0b, 1'b0, 2);
		conclude;
	end
endmodule : test_msg_report
bind msg_report msg_report_sva chk_u (.clock, .rst, .clk_en, .port_enable, .in_valid, .in_ready,
	.in_kind, .in_req_bus, .msg_valid, .msg_data, .msg_kind);
